//--- common/amcmd_pkg.sv
// Overview of operation
// RULE1 - Set-max answers with ack and error code
// RULE2 - Host clears transmit bit after each ack
// RULE3 - No new command until transmit clears
// RULE4 - Set-max needs 100 counts from other points
// RULE5 - Edits take effect only on mode exit
// RULE6 - Unsaved edits dropped on exit without save
// RULE7 - Edits dropped on reset in alignment mode
// RULE8 - Save-exit 800E stores, acks, leaves alignment
// RULE9 - Save-exit refused until required points set
// RULE10 - After save-exit enter measurement mode
// RULE11 - Abort-exit 800F discards edits and acks
// RULE12 - Abort returns to alignment unless channel aligned
// RULE13 - Any exit goes measuring if channel aligned
// RULE14 - Power-up sets initialized, measurement if ready
// RULE15 - Channel ready means calibrated, configured, aligned
// RULE16 - Begin-measurement 880X selects enabled channels
// RULE17 - Measurement reports position and velocity
// RULE18 - Alignment reports raw converter sign-magnitude
// RULE19 - Set-max 900A carries value in words 1-2
// RULE20 - Execute once on transmit rising edge
package amcmd_pkg;
   localparam int NWORDS = 10;
   localparam int TX_BIT = 15;
   // Command codes
   localparam logic [15:0] CMD_SET_MAX = 16'h900a;
   localparam logic [15:0] CMD_SAVE_EXIT = 16'h800e;
   localparam logic [15:0] CMD_ABORT_EXIT = 16'h800f;
   localparam logic [15:0] CMD_MEAS_BASE = 16'h8800;
   localparam logic [15:0] CMD_MEAS_MASK = 16'hfffc;
   // Module status word bits
   localparam int MS_ACK_BIT = 15;
   localparam int MS_INIT_BIT = 12;
   localparam int MS_ALIGN_BIT = 9;
   localparam int MS_MEAS_BIT = 8;
   // Channel status word bits
   localparam int CS_CAL_BIT = 14;
   localparam int CS_CFG_BIT = 13;
   localparam int CS_ALN_BIT = 12;
   localparam int CS_EN_BIT = 0;
   // Error codes in status bits 3..0
   localparam logic [3:0] ERR_NONE = 4'h0;
   localparam logic [3:0] ERR_BAD_CMD = 4'h1;
   localparam logic [3:0] ERR_TOO_CLOSE = 4'h2;
   localparam logic [3:0] ERR_POINTS = 4'h3;
   localparam logic [3:0] ERR_MODE = 4'h4;
   localparam int MIN_SEP = 100;
   // Input word layout: status word, position pair, velocity per channel
   localparam int IW_MOD = 0;
   localparam int IW_CH_BASE = 1;
   localparam int IW_CH_STRIDE = 4;
   localparam int NPOINTS = 3;
   localparam logic [15:0] RST_WORD = 16'h0000;
   // Host register byte offsets
   localparam logic [7:0] OFF_CMD = 8'h00;
   localparam logic [7:0] OFF_ARG_HI = 8'h04;
   localparam logic [7:0] OFF_ARG_LO = 8'h08;
   localparam logic [7:0] OFF_CTRL = 8'h0c;
   localparam logic [7:0] OFF_STAT = 8'h10;
   localparam logic [7:0] OFF_IN_BASE = 8'h20;
   typedef enum logic [1:0] {
      AMCMD_M_BOOT = 2'b00,
      AMCMD_M_ALIGN = 2'b01,
      AMCMD_M_MEAS = 2'b10
   } amcmd_mode_t;
   typedef enum logic [1:0] {
      AMCMD_H_IDLE = 2'b00,
      AMCMD_H_WAIT_ACK = 2'b01,
      AMCMD_H_WAIT_CLR = 2'b10
   } amcmd_hstate_t;
endpackage : amcmd_pkg

//--- common/amcmd_if.sv
`timescale 1ns/1ps
// Ten command words out from the host, ten data words back from the device
interface amcmd_if;
   logic [amcmd_pkg::NWORDS-1:0][15:0] out_w;
   logic [amcmd_pkg::NWORDS-1:0][15:0] in_w;
   modport dev (input out_w, output in_w);
   modport host (output out_w, input in_w);
endinterface : amcmd_if

//--- src/amcmd_sep.sv
`timescale 1ns/1ps
// Checks that the reading is far enough from every defined point
module amcmd_sep #(
   parameter int ADC_W = 16,
   parameter int NPT = 2
) (
   input wire logic [ADC_W-1:0] adc,
   input wire logic [NPT-1:0][ADC_W-1:0] pt_adc,
   input wire logic [NPT-1:0] pt_set,
   output logic far
);
   localparam logic [ADC_W:0] SEP = (ADC_W+1)'(amcmd_pkg::MIN_SEP);
   logic [NPT-1:0] ok;
   // One signed distance per point; undefined points never block
   for (genvar i = 0; i < NPT; i++) begin : g_pt
      logic signed [ADC_W:0] d;
      logic [ADC_W:0] mag;
      assign d = $signed({adc[ADC_W-1], adc}) - $signed({pt_adc[i][ADC_W-1], pt_adc[i]});
      assign mag = d[ADC_W] ? (ADC_W+1)'(-d) : d;
      assign ok[i] = !pt_set[i] || (mag >= SEP); // see RULE4
   end
   assign far = &ok;
endmodule : amcmd_sep

//--- src/amcmd_dev.sv
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// Device end: interprets command blocks, keeps alignment edits and modes
module amcmd_dev #(
   parameter int ADC_W = 16
) (
   input wire logic clk,
   input wire logic reset,
   amcmd_if.dev link,
   input wire logic [1:0][ADC_W-1:0] adc_raw,
   input wire logic [1:0][31:0] pos_sm,
   input wire logic [1:0][15:0] vel,
   input wire logic [1:0] nv_cal,
   input wire logic [1:0] nv_cfg,
   input wire logic [1:0] nv_aligned,
   input wire logic align_ch,
   input wire logic [amcmd_pkg::NPOINTS-1:0] req_pts,
   input wire logic [1:0] pre_set,
   input wire logic [1:0][ADC_W-1:0] pre_adc,
   output logic nv_wr,
   output logic nv_ch,
   output logic [31:0] nv_max,
   output logic [1:0][31:0] act_max,
   output logic [1:0] ch_en,
   output logic meas_mode
);
   typedef struct packed {
      logic booted;
      amcmd_pkg::amcmd_mode_t mode;
      logic tx_q;
      logic ack;
      logic [3:0] err;
      logic [1:0] cal;
      logic [1:0] cfg;
      logic [1:0] aln;
      logic [31:0] ed_max;
      logic ed_set;
      logic [1:0][31:0] act_max;
      logic [1:0] ch_en;
      logic nv_wr;
      logic nv_ch;
      logic [31:0] nv_max;
      logic meas;
      logic [amcmd_pkg::NWORDS-1:0][15:0] in_w;
   } amcmd_dev_st_t;

   amcmd_dev_st_t s_r;
   amcmd_dev_st_t s_nxt;
   logic far;
   logic [15:0] w0;
   logic tx;
   logic edge_tx;
   logic tail_zero;
   logic args_zero;
   logic [1:0] ready;
   logic [1:0] ready_nxt;
   logic [amcmd_pkg::NPOINTS-1:0] have_pts;

   // Raw reading to 32-bit sign-magnitude
   function automatic logic [31:0] to_sm(input logic [ADC_W-1:0] v);
      logic [ADC_W-1:0] mag;
      mag = v[ADC_W-1] ? ADC_W'(-v) : v;
      return {v[ADC_W-1], 31'(mag)};
   endfunction : to_sm

   // Distance check against the null and minimum points of this channel
   amcmd_sep #(
      .ADC_W(ADC_W),
      .NPT(2)
   ) u_sep (
      .adc(adc_raw[align_ch]),
      .pt_adc(pre_adc),
      .pt_set(pre_set),
      .far(far)
   );

   // Command block decode helpers
   assign w0 = link.out_w[0];
   assign tx = w0[amcmd_pkg::TX_BIT];
   assign edge_tx = tx && !s_r.tx_q; // see RULE20
   assign tail_zero = ~|link.out_w[amcmd_pkg::NWORDS-1:3];
   assign args_zero = tail_zero && ~|link.out_w[2:1];
   assign ready = s_r.cal & s_r.cfg & s_r.aln; // see RULE15
   assign have_pts = {s_r.ed_set, pre_set};

   // Next state
   always_comb begin
      s_nxt = s_r;
      s_nxt.nv_wr = 1'b0;
      s_nxt.tx_q = tx;
      if (!s_r.booted) begin
         // Straps caught once, the first cycle after reset
         s_nxt.booted = 1'b1;
         s_nxt.cal = nv_cal;
         s_nxt.cfg = nv_cfg;
         s_nxt.aln = nv_aligned;
         if (|(nv_cal & nv_cfg & nv_aligned)) begin
            s_nxt.mode = amcmd_pkg::AMCMD_M_MEAS; // see RULE14
         end else begin
            s_nxt.mode = amcmd_pkg::AMCMD_M_ALIGN;
         end
      end else if (!tx) begin
         s_nxt.ack = 1'b0; // see RULE3
      end else if (edge_tx && !s_r.ack) begin
         // Acked commands are held off until transmit drops again
         s_nxt.ack = 1'b1; // see RULE1
         s_nxt.err = amcmd_pkg::ERR_NONE;
         if (w0 == amcmd_pkg::CMD_SET_MAX) begin
            if (s_r.mode != amcmd_pkg::AMCMD_M_ALIGN) begin
               s_nxt.err = amcmd_pkg::ERR_MODE;
            end else if (!tail_zero) begin
               s_nxt.err = amcmd_pkg::ERR_BAD_CMD;
            end else if (!far) begin
               s_nxt.err = amcmd_pkg::ERR_TOO_CLOSE; // see RULE4
            end else begin
               // Kept as an edit only; active value untouched here
               s_nxt.ed_max = {link.out_w[1], link.out_w[2]}; // see RULE19
               s_nxt.ed_set = 1'b1; // see RULE5
            end
         end else if (w0 == amcmd_pkg::CMD_SAVE_EXIT) begin
            if (s_r.mode != amcmd_pkg::AMCMD_M_ALIGN) begin
               s_nxt.err = amcmd_pkg::ERR_MODE;
            end else if (!args_zero) begin
               s_nxt.err = amcmd_pkg::ERR_BAD_CMD;
            end else if ((req_pts & have_pts) != req_pts) begin
               s_nxt.err = amcmd_pkg::ERR_POINTS; // see RULE9
            end else begin
               if (s_r.ed_set) begin
                  s_nxt.act_max[align_ch] = s_r.ed_max; // see RULE5
               end
               s_nxt.nv_wr = 1'b1; // see RULE8
               s_nxt.nv_ch = align_ch;
               s_nxt.nv_max = s_r.ed_set ? s_r.ed_max : s_r.act_max[align_ch];
               s_nxt.aln[align_ch] = 1'b1;
               s_nxt.ed_set = 1'b0;
               s_nxt.mode = amcmd_pkg::AMCMD_M_MEAS; // see RULE10
            end
         end else if (w0 == amcmd_pkg::CMD_ABORT_EXIT) begin // see RULE11
            if (s_r.mode != amcmd_pkg::AMCMD_M_ALIGN) begin
               s_nxt.err = amcmd_pkg::ERR_MODE;
            end else if (!args_zero) begin
               s_nxt.err = amcmd_pkg::ERR_BAD_CMD;
            end else begin
               s_nxt.ed_set = 1'b0; // see RULE6
               if (|ready) begin
                  s_nxt.mode = amcmd_pkg::AMCMD_M_MEAS; // see RULE13
               end else begin
                  s_nxt.mode = amcmd_pkg::AMCMD_M_ALIGN; // see RULE12
               end
            end
         end else if ((w0 & amcmd_pkg::CMD_MEAS_MASK) == amcmd_pkg::CMD_MEAS_BASE) begin
            if (s_r.mode != amcmd_pkg::AMCMD_M_MEAS) begin
               s_nxt.err = amcmd_pkg::ERR_MODE;
            end else if (!args_zero) begin
               s_nxt.err = amcmd_pkg::ERR_BAD_CMD;
            end else begin
               // A channel that is not ready stays off
               s_nxt.ch_en = w0[1:0] & ready; // see RULE16
            end
         end else begin
            s_nxt.err = amcmd_pkg::ERR_BAD_CMD;
         end
      end
      // Input data words follow the next state so they match the flags
      ready_nxt = s_nxt.cal & s_nxt.cfg & s_nxt.aln;
      // Mode flag registered so the pin comes straight from a flop
      s_nxt.meas = (s_nxt.mode == amcmd_pkg::AMCMD_M_MEAS);
      s_nxt.in_w = '0;
      s_nxt.in_w[amcmd_pkg::IW_MOD][amcmd_pkg::MS_ACK_BIT] = s_nxt.ack;
      s_nxt.in_w[amcmd_pkg::IW_MOD][amcmd_pkg::MS_INIT_BIT] = s_nxt.booted; // see RULE14
      s_nxt.in_w[amcmd_pkg::IW_MOD][amcmd_pkg::MS_MEAS_BIT] =
         (s_nxt.mode == amcmd_pkg::AMCMD_M_MEAS);
      s_nxt.in_w[amcmd_pkg::IW_MOD][amcmd_pkg::MS_ALIGN_BIT] =
         (s_nxt.mode == amcmd_pkg::AMCMD_M_ALIGN);
      s_nxt.in_w[amcmd_pkg::IW_MOD][3:0] = s_nxt.err; // see RULE1
      for (int c = 0; c < 2; c++) begin
         int b;
         b = amcmd_pkg::IW_CH_BASE + amcmd_pkg::IW_CH_STRIDE * c;
         s_nxt.in_w[b][amcmd_pkg::CS_CAL_BIT] = s_nxt.cal[c];
         s_nxt.in_w[b][amcmd_pkg::CS_CFG_BIT] = s_nxt.cfg[c];
         s_nxt.in_w[b][amcmd_pkg::CS_ALN_BIT] = s_nxt.aln[c]; // see RULE15
         s_nxt.in_w[b][amcmd_pkg::CS_EN_BIT] = s_nxt.ch_en[c] && ready_nxt[c];
         if (s_nxt.mode == amcmd_pkg::AMCMD_M_MEAS && s_nxt.ch_en[c]) begin
            {s_nxt.in_w[b+1], s_nxt.in_w[b+2]} = pos_sm[c]; // see RULE17
            s_nxt.in_w[b+3] = vel[c];
         end else if (s_nxt.mode == amcmd_pkg::AMCMD_M_ALIGN) begin
            {s_nxt.in_w[b+1], s_nxt.in_w[b+2]} = to_sm(adc_raw[c]); // see RULE18
         end
      end
   end

   // State register; reset clears every edit
   always_ff @(posedge clk) begin
      if (reset) begin
         s_r <= '0; // see RULE7
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from the state register
   assign link.in_w = s_r.in_w;
   assign nv_wr = s_r.nv_wr;
   assign nv_ch = s_r.nv_ch;
   assign nv_max = s_r.nv_max;
   assign act_max = s_r.act_max;
   assign ch_en = s_r.ch_en;
   assign meas_mode = s_r.meas;
endmodule : amcmd_dev

//--- src/amcmd_host.sv
`timescale 1ns/1ps
// Host end: APB registers drive one command block handshake at a time
module amcmd_host (
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   amcmd_if.host link
);
   typedef struct packed {
      amcmd_pkg::amcmd_hstate_t st;
      logic [15:0] cmd;
      logic [15:0] arg_hi;
      logic [15:0] arg_lo;
      logic [15:0] last_stat;
      logic [amcmd_pkg::NWORDS-1:0][15:0] out_w;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } amcmd_host_st_t;

   amcmd_host_st_t s_r;
   amcmd_host_st_t s_nxt;
   logic [7:0] in_off;
   logic in_hit;
   logic hit;
   logic [31:0] rd;
   logic go;
   logic ackd;

   assign in_off = paddr - amcmd_pkg::OFF_IN_BASE;
   assign in_hit = (paddr >= amcmd_pkg::OFF_IN_BASE) && (in_off[1:0] == 2'b00)
      && (in_off[7:2] < 6'(amcmd_pkg::NWORDS));
   assign ackd = link.in_w[amcmd_pkg::IW_MOD][amcmd_pkg::MS_ACK_BIT];

   // Read mux and address decode
   always_comb begin
      rd = '0;
      hit = 1'b1;
      if (paddr == amcmd_pkg::OFF_CMD) begin
         rd = {16'h0000, s_r.cmd};
      end else if (paddr == amcmd_pkg::OFF_ARG_HI) begin
         rd = {16'h0000, s_r.arg_hi};
      end else if (paddr == amcmd_pkg::OFF_ARG_LO) begin
         rd = {16'h0000, s_r.arg_lo};
      end else if (paddr == amcmd_pkg::OFF_CTRL) begin
         rd = '0;
      end else if (paddr == amcmd_pkg::OFF_STAT) begin
         rd = {s_r.last_stat, 15'h0000, s_r.st != amcmd_pkg::AMCMD_H_IDLE};
      end else if (in_hit) begin
         rd = {16'h0000, link.in_w[in_off[5:2]]};
      end else begin
         hit = 1'b0;
      end
   end

   // Next state; writes land on the edge that completes the access
   always_comb begin
      s_nxt = s_r;
      go = 1'b0;
      s_nxt.pready = 1'b0;
      s_nxt.pslverr = 1'b0;
      if (psel && penable && !s_r.pready) begin
         s_nxt.pready = 1'b1;
         s_nxt.pslverr = !hit;
         s_nxt.prdata = pwrite ? 32'h0000_0000 : rd;
      end
      if (psel && penable && s_r.pready && pwrite && !s_r.pslverr) begin
         unique case (paddr)
            amcmd_pkg::OFF_CMD: s_nxt.cmd = pwdata[15:0];
            amcmd_pkg::OFF_ARG_HI: s_nxt.arg_hi = pwdata[15:0];
            amcmd_pkg::OFF_ARG_LO: s_nxt.arg_lo = pwdata[15:0];
            amcmd_pkg::OFF_CTRL: go = pwdata[0];
            default: ;
         endcase
      end
      // Handshake: send, wait ack, clear word 0, wait ack to drop
      unique case (s_r.st)
         amcmd_pkg::AMCMD_H_IDLE: begin
            if (go) begin
               s_nxt.out_w = '0;
               s_nxt.out_w[1] = s_r.arg_hi;
               s_nxt.out_w[2] = s_r.arg_lo;
               s_nxt.out_w[0] = s_r.cmd | 16'h8000; // see RULE20
               s_nxt.st = amcmd_pkg::AMCMD_H_WAIT_ACK;
            end
         end
         amcmd_pkg::AMCMD_H_WAIT_ACK: begin
            if (ackd) begin
               s_nxt.last_stat = link.in_w[amcmd_pkg::IW_MOD];
               s_nxt.out_w = '0; // see RULE2
               s_nxt.st = amcmd_pkg::AMCMD_H_WAIT_CLR;
            end
         end
         amcmd_pkg::AMCMD_H_WAIT_CLR: begin
            if (!ackd) begin
               s_nxt.st = amcmd_pkg::AMCMD_H_IDLE; // see RULE3
            end
         end
         default: s_nxt.st = amcmd_pkg::AMCMD_H_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign prdata = s_r.prdata;
   assign pready = s_r.pready;
   assign pslverr = s_r.pslverr;
   assign link.out_w = s_r.out_w;
endmodule : amcmd_host

//--- dv/amcmd_assertions.sv
`timescale 1ns/1ps
// Watches the command link between the host end and the device end
module amcmd_assertions (
   input wire logic clk,
   input wire logic reset,
   input wire logic [amcmd_pkg::NWORDS-1:0][15:0] out_w,
   input wire logic [amcmd_pkg::NWORDS-1:0][15:0] in_w
);
   logic tx;
   logic ack;
   logic meas;
   logic aln;
   logic rdy1;
   logic rdy2;
   logic [3:0] err;
   // Field taps; ready needs all three channel flags
   assign tx = out_w[0][15];
   assign ack = in_w[0][15];
   assign meas = in_w[0][8];
   assign aln = in_w[0][9];
   assign err = in_w[0][3:0];
   assign rdy1 = &in_w[1][14:12];
   assign rdy2 = &in_w[5][14:12];
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   a_ack_on_tx: assert property ($rose(tx) && !ack |=> ack)
      else $error("no ack one cycle after transmit rose");
   a_ack_holds: assert property (ack && tx |=> ack)
      else $error("ack dropped while transmit high");
   a_ack_clears: assert property (ack && !tx |=> !ack)
      else $error("ack stayed after transmit cleared");
   a_single_exec: assert property ($rose(ack) |-> $past(tx) && !$past(tx, 2))
      else $error("ack rose without a fresh transmit edge");
   a_err_holds: assert property (!($rose(tx) && !ack) |=> $stable(err))
      else $error("error code changed without a command");
   a_save_meas: assert property ($rose(ack) && out_w[0] == amcmd_pkg::CMD_SAVE_EXIT
      && err == 4'h0 |-> meas && !aln)
      else $error("save exit did not reach measurement mode");
   a_abort_mode: assert property ($rose(ack) && out_w[0] == amcmd_pkg::CMD_ABORT_EXIT
      && err == 4'h0 |-> meas == (rdy1 || rdy2) && aln == !meas)
      else $error("abort exit chose the wrong mode");
   a_meas_ready: assert property (meas |-> in_w[0][12] && (rdy1 || rdy2))
      else $error("measurement mode without a ready channel");
   a_en_ready: assert property (in_w[1][0] |-> rdy1 && meas)
      else $error("channel enabled while not ready");
   a_vel_gated: assert property (!(meas && in_w[1][0]) |-> in_w[4] == 16'h0000)
      else $error("velocity shown for an idle channel");
   // Main scenarios reached
   c_save: cover property ($rose(ack) && out_w[0] == amcmd_pkg::CMD_SAVE_EXIT && err == 4'h0);
   c_abort: cover property ($rose(ack) && out_w[0] == amcmd_pkg::CMD_ABORT_EXIT);
   c_too_close: cover property ($rose(ack) && err == amcmd_pkg::ERR_TOO_CLOSE);
endmodule : amcmd_assertions

//--- dv/amcmd_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
   $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module amcmd_tb;
   typedef struct packed {
      logic [15:0] adc, cmd, hi, lo, st;
      logic [1:0] en;
      logic [31:0] mx;
   } amcmd_row_t;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic align_ch = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, nv_max, rd;
   logic pready, pslverr, nv_wr, nv_ch, meas_mode, er;
   logic [1:0][15:0] adc_raw, pre_adc, vel;
   logic [1:0][31:0] pos_sm, act_max;
   logic [1:0] nv_aligned, pre_set, ch_en;
   logic [2:0] req_pts;
   logic [15:0] st;
   int fail_count = 0;
   int cmp_count = 0;
   int nv_cnt = 0;
   amcmd_row_t rows [15];
   amcmd_if link ();
   always #4 clk = ~clk;
   // Counts save pulses so a repeated write shows up
   always @(posedge clk) begin
      if (nv_wr === 1'b1) nv_cnt++;
   end
   amcmd_host i_amcmd_host (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(link));
   amcmd_dev i_amcmd_dev (.clk(clk), .reset(reset), .link(link), .adc_raw(adc_raw),
      .pos_sm(pos_sm), .vel(vel), .nv_cal(2'b11), .nv_cfg(2'b11), .nv_aligned(nv_aligned),
      .align_ch(align_ch), .req_pts(req_pts), .pre_set(pre_set), .pre_adc(pre_adc),
      .nv_wr(nv_wr), .nv_ch(nv_ch), .nv_max(nv_max), .act_max(act_max), .ch_en(ch_en),
      .meas_mode(meas_mode));
   amcmd_assertions i_amcmd_assertions (.clk(clk), .reset(reset), .out_w(link.out_w),
      .in_w(link.in_w));
   task automatic stop_test;
      $display("mismatches %0d comparisons %0d", fail_count, cmp_count);
      if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test
   // One APB transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         fail_count++;
         stop_test();
      end
      @(posedge clk);
   endtask : apb
   // Loads a command block, fires go, waits for the handshake to close
   task automatic cmd(input amcmd_row_t r);
      int n;
      n = 0;
      adc_raw[align_ch] <= r.adc;
      apb(1'b1, amcmd_pkg::OFF_ARG_HI, {16'h0, r.hi});
      apb(1'b1, amcmd_pkg::OFF_ARG_LO, {16'h0, r.lo});
      apb(1'b1, amcmd_pkg::OFF_CMD, {16'h0, r.cmd});
      apb(1'b1, amcmd_pkg::OFF_CTRL, 32'h1);
      do begin
         apb(1'b0, amcmd_pkg::OFF_STAT, 32'h0);
         n++;
      end while (rd[0] !== 1'b0 && n < 20);
      if (n >= 20) begin
         fail_count++;
         stop_test();
      end
      st = rd[31:16];
   endtask : cmd
   task automatic do_reset;
      reset <= 1'b1;
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
   endtask : do_reset
   // Straps: both channels calibrated and configured, none aligned
   initial begin
      adc_raw = {16'h0010, 16'hfe0c};
      pre_adc = {16'hfe0c, 16'h0000};
      pos_sm = {32'h0, 32'h12345678};
      vel = {16'h0, 16'habcd};
      nv_aligned = 2'b00;
      pre_set = 2'b11;
      req_pts = 3'b111;
      rows = '{'{16'h0064, 16'h8801, 16'h0, 16'h0, 16'h9204, 2'b00, 32'h0},
         '{16'h0064, 16'h800e, 16'h0, 16'h0, 16'h9203, 2'b00, 32'h0},
         '{16'h0063, 16'h900a, 16'h0, 16'h5, 16'h9202, 2'b00, 32'h0},
         '{16'hfe6f, 16'h900a, 16'h0, 16'h5, 16'h9202, 2'b00, 32'h0},
         '{16'hff9c, 16'h900a, 16'h0, 16'h5, 16'h9200, 2'b00, 32'h0},
         '{16'hff9c, 16'h9001, 16'h0, 16'h0, 16'h9201, 2'b00, 32'h0},
         '{16'hff9c, 16'h800f, 16'h0, 16'h0, 16'h9200, 2'b00, 32'h0},
         '{16'hff9c, 16'h800e, 16'h0, 16'h0, 16'h9203, 2'b00, 32'h0},
         '{16'h0064, 16'h900a, 16'h1, 16'h2, 16'h9200, 2'b00, 32'h0},
         '{16'h0064, 16'h800e, 16'h0, 16'h0, 16'h9100, 2'b00, 32'h00010002},
         '{16'h0064, 16'h8803, 16'h0, 16'h0, 16'h9100, 2'b01, 32'h00010002},
         '{16'h0064, 16'h8802, 16'h0, 16'h0, 16'h9100, 2'b00, 32'h00010002},
         '{16'h0064, 16'h8804, 16'h0, 16'h0, 16'h9101, 2'b00, 32'h00010002},
         '{16'h0064, 16'h8800, 16'h0, 16'h0, 16'h9100, 2'b00, 32'h00010002},
         '{16'h0064, 16'h8801, 16'h0, 16'h0, 16'h9100, 2'b01, 32'h00010002}};
      do_reset();
      apb(1'b0, 8'h20, 32'h0);
      `CHK(rd[15:0], 16'h1200)
      apb(1'b0, 8'h28, 32'h0);
      `CHK(rd[15:0], 16'h8000)
      apb(1'b0, 8'h2c, 32'h0);
      `CHK(rd[15:0], 16'h01f4)
      apb(1'b0, 8'h3c, 32'h0);
      `CHK(rd[15:0], 16'h0010)
      apb(1'b0, 8'h80, 32'h0);
      `CHK({er, rd}, {1'b1, 32'h0})
      foreach (rows[i]) begin
         cmd(rows[i]);
         `CHK(st, rows[i].st)
         `CHK(ch_en, rows[i].en)
         `CHK(act_max[0], rows[i].mx)
         `CHK(meas_mode, rows[i].st[8])
      end
      `CHK({nv_ch, nv_max}, {1'b0, 32'h00010002})
      `CHK(nv_cnt, 1)
      // Channel 1 enabled in measurement mode, channel 2 idle
      apb(1'b0, 8'h28, 32'h0);
      `CHK(rd[15:0], 16'h1234)
      apb(1'b0, 8'h2c, 32'h0);
      `CHK(rd[15:0], 16'h5678)
      apb(1'b0, 8'h30, 32'h0);
      `CHK(rd[15:0], 16'habcd)
      apb(1'b0, 8'h38, 32'h0);
      `CHK(rd[15:0], 16'h0000)
      // An accepted edit lost to reset leaves the save short of points
      do_reset();
      cmd(rows[8]);
      `CHK(st, 16'h9200)
      do_reset();
      cmd(rows[1]);
      `CHK(st, 16'h9203)
      // Second channel aligned: its own max, save target and enable mask
      align_ch <= 1'b1;
      do_reset();
      cmd(rows[8]);
      `CHK(st, 16'h9200)
      cmd(rows[9]);
      `CHK({st, act_max[1], act_max[0]}, {16'h9100, 32'h00010002, 32'h0})
      `CHK({nv_ch, nv_max}, {1'b1, 32'h00010002})
      cmd(rows[10]);
      `CHK(ch_en, 2'b10)
      // Abort is refused once alignment mode has been left
      cmd(rows[6]);
      `CHK(st, 16'h9104)
      nv_aligned <= 2'b10;
      do_reset();
      apb(1'b0, 8'h20, 32'h0);
      `CHK(rd[15:0], 16'h1100)
      apb(1'b0, 8'h34, 32'h0);
      `CHK(rd[15:0], 16'h7000)
      apb(1'b0, 8'h24, 32'h0);
      `CHK(rd[15:0], 16'h6000)
      stop_test();
   end
endmodule : amcmd_tb
